/* File: fic_cmp.v */
// Faulty versus golden output comparator
`include "fic_defines.vh"
module fic_cmp (
   input  wire [`FIC_OUTW-1:0] faulty_in,
   input  wire [`FIC_OUTW-1:0] golden_in,
   output wire [`FIC_OUTW-1:0] diff_out,
   output wire                 mismatch_out
);
   assign diff_out     = faulty_in ^ golden_in;
   assign mismatch_out = |diff_out;
endmodule

/* File: fic_defines.vh */
// Constants shared by the fault injection campaign runner files
`ifndef FIC_DEFINES_VH
`define FIC_DEFINES_VH
`define FIC_AW          4
`define FIC_DW          32
`define FIC_OUTW        8
`define FIC_REGW        8
`define FIC_CYCW        16
`define FIC_RUNW        4
`define FIC_BATW        5
`define FIC_SLOTW       2
`define FIC_MAW         6
`define FIC_INJW        25
`define FIC_RESW        28
`define FIC_DMGW        8
`define FIC_KW          3
`define FIC_RCW         7
`define FIC_OPTW        6
`define FIC_A_CTRL      4'h0
`define FIC_A_OPTS      4'h1
`define FIC_A_DMGLIM    4'h2
`define FIC_A_MAXINJ    4'h3
`define FIC_A_DUMPINT   4'h4
`define FIC_A_RELOADINT 4'h5
`define FIC_A_BATCH     4'h6
`define FIC_A_VECCNT    4'h7
`define FIC_A_INJADDR   4'h8
`define FIC_A_INJDATA   4'h9
`define FIC_A_RESADDR   4'ha
`define FIC_A_RESDATA   4'hb
`define FIC_A_RESCNT    4'hc
`define FIC_A_POS       4'hd
`define FIC_CTRL_START  0
`define FIC_ST_BUSY     0
`define FIC_ST_DONE     1
`define FIC_OPT_RESID   0
`define FIC_OPT_DROP    1
`define FIC_OPT_MASK    2
`define FIC_OPT_UNFLIP  3
`define FIC_OPT_DUMPERR 4
`define FIC_OPT_RLDERR  5
`define FIC_OPT_RST     6'h02
`define FIC_DMG_RST     8'h01
`define FIC_MAXINJ_RST  3'h1
`define FIC_MAXINJ_TOP  3'h4
`define FIC_BATCH_RST   5'h01
`define FIC_INJ_VALID   24
`define FIC_INJ_CYC_HI  23
`define FIC_INJ_CYC_LO  8
`define FIC_INJ_REG_HI  7
`define FIC_RES_FULL    7'h40
`endif

/* File: fic_mem.v */
// Simple dual port memory with registered read data
module fic_mem #(
   parameter W  = 25,
   parameter AW = 6
) (
   input  wire          clk_in,
   input  wire          we_in,
   input  wire [AW-1:0] waddr_in,
   input  wire [W-1:0]  wdata_in,
   input  wire [AW-1:0] raddr_in,
   output reg  [W-1:0]  rdata_out
);
   reg [W-1:0] mem_r [0:(1<<AW)-1];

   always @(posedge clk_in) begin
      if (we_in) begin
         mem_r[waddr_in] <= wdata_in;
      end
      rdata_out <= mem_r[raddr_in];
   end
endmodule

/* File: fic_runner.v */
// Fault injection campaign run sequencer
// Contract
// - By default compare only after first injection, stop at damage limit.
// - Residual check compares from the first cycle of every run.
// - Keep comparing while damage count is below the per-run limit.
// - Drop setting 1: reaching limit ends the run at once.
// - Drop setting 0: keep stepping remaining cycles, no more comparisons.
// - Compare target outputs against golden outputs on every active cycle.
// - Mismatch records the cycle number and increments damage count.
// - Mask option adds per-output difference bitmask to each record.
// - Step vectors in order until the run ends; flip chosen bit at injection cycles.
// - No more injections than the per-run maximum, from the supplied list.
// - Dump option: dump target after each run with damage.
// - Nonzero dump interval N: dump after every Nth run.
// - Any dump option: dump target once for the golden run.
// - End of run order: dump, then unflip, then reload.
// - Unflip option: re-invert every bit flipped during the run.
// - Reload option: reconfigure target after each run with damage.
// - Nonzero reload interval N: reconfigure after every Nth run.
// - With repair options off runs continue without correction.
// - Process batches of up to 16 runs and hold results until read back.
`include "fic_defines.vh"
module fic_runner (
   input  wire                 clk_in,
   input  wire                 arst_n_in,
   input  wire [`FIC_AW-1:0]   addr_in,
   input  wire [`FIC_DW-1:0]   wdata_in,
   input  wire                 wr_in,
   input  wire                 rd_in,
   output reg  [`FIC_DW-1:0]   rdata_out,
   input  wire [`FIC_OUTW-1:0] tgt_out_in,
   input  wire [`FIC_OUTW-1:0] gold_out_in,
   output reg                  step_out,
   output reg  [`FIC_CYCW-1:0] vec_idx_out,
   output reg                  flip_out,
   output reg  [`FIC_REGW-1:0] flip_reg_out,
   output reg                  dump_req_out,
   output reg                  dump_golden_out,
   input  wire                 dump_done_in,
   output reg                  reload_req_out,
   input  wire                 reload_done_in,
   output reg                  busy_out,
   output reg                  done_out
);
   localparam [13:0] S_IDLE  = 14'h0001;
   localparam [13:0] S_GDUMP = 14'h0002;
   localparam [13:0] S_RSTRT = 14'h0004;
   localparam [13:0] S_STEP  = 14'h0008;
   localparam [13:0] S_CMP   = 14'h0010;
   localparam [13:0] S_ICHK  = 14'h0020;
   localparam [13:0] S_INJW  = 14'h0040;
   localparam [13:0] S_ENDR  = 14'h0080;
   localparam [13:0] S_DUMP  = 14'h0100;
   localparam [13:0] S_UNFS  = 14'h0200;
   localparam [13:0] S_UNFW  = 14'h0400;
   localparam [13:0] S_UNFF  = 14'h0800;
   localparam [13:0] S_RLD   = 14'h1000;
   localparam [13:0] S_RNEXT = 14'h2000;

   function period_hit;
      input [7:0] cnt;
      input [7:0] n;
      begin
         period_hit = (n != 8'h00) && ((cnt + 8'h01) == n);
      end
   endfunction

   function [7:0] period_next;
      input [7:0] cnt;
      input [7:0] n;
      begin
         period_next = period_hit(cnt, n) ? 8'h00 : cnt + 8'h01;
      end
   endfunction

   reg                   rs1_r;
   reg                   rs2_r;
   wire                  rst_n = rs2_r;

   reg [13:0]            st_r;
   reg [`FIC_OPTW-1:0]   opt_r;
   reg [`FIC_DMGW-1:0]   dmg_lim_r;
   reg [`FIC_KW-1:0]     max_inj_r;
   reg [7:0]             dump_int_r;
   reg [7:0]             rld_int_r;
   reg [`FIC_BATW-1:0]   batch_r;
   reg [`FIC_CYCW-1:0]   vec_cnt_r;
   reg [`FIC_MAW-1:0]    inj_addr_r;
   reg [`FIC_MAW-1:0]    res_addr_r;
   reg [`FIC_RCW-1:0]    res_cnt_r;
   reg [`FIC_RUNW-1:0]   run_r;
   reg [`FIC_CYCW-1:0]   cyc_r;
   reg [`FIC_DMGW-1:0]   dmg_r;
   reg                   injected_r;
   reg [`FIC_KW-1:0]     k_r;
   reg [`FIC_KW-1:0]     u_r;
   reg [7:0]             dump_pc_r;
   reg [7:0]             rld_pc_r;
   reg                   rld_need_r;

   wire                  wr_ctrl = wr_in && (addr_in == `FIC_A_CTRL);
   wire                  start   = wr_ctrl && wdata_in[`FIC_CTRL_START] && !busy_out;
   wire                  inj_we  = wr_in && (addr_in == `FIC_A_INJDATA);
   wire                  dump_any = opt_r[`FIC_OPT_DUMPERR] || (dump_int_r != 8'h00);
   wire                  unf_ph  = (st_r == S_UNFW) || (st_r == S_UNFF);
   wire [`FIC_SLOTW-1:0] slot    = unf_ph ? u_r[`FIC_SLOTW-1:0] : k_r[`FIC_SLOTW-1:0];
   wire [`FIC_INJW-1:0]  inj_q;
   wire [`FIC_RESW-1:0]  res_q;
   wire [`FIC_OUTW-1:0]  diff;
   wire                  mismatch;
   wire [`FIC_CYCW-1:0]  inj_cyc = inj_q[`FIC_INJ_CYC_HI:`FIC_INJ_CYC_LO];
   wire [`FIC_REGW-1:0]  inj_reg = inj_q[`FIC_INJ_REG_HI:0];
   wire                  cmp_en  = (injected_r || opt_r[`FIC_OPT_RESID]) && (dmg_r < dmg_lim_r);
   wire                  rec     = (st_r == S_CMP) && cmp_en && mismatch;
   wire                  res_we  = rec && (res_cnt_r < `FIC_RES_FULL);
   wire [`FIC_OUTW-1:0]  rec_mask = opt_r[`FIC_OPT_MASK] ? diff : {`FIC_OUTW{1'b0}};
   wire [`FIC_RESW-1:0]  res_wd  = {run_r, cyc_r, rec_mask};
   wire                  last_cyc = (cyc_r + 16'h0001) == vec_cnt_r;
   wire                  last_run = ({1'b0, run_r} + 5'h01) == batch_r;
   wire                  inj_hit = (k_r < max_inj_r) && inj_q[`FIC_INJ_VALID] && (inj_cyc == cyc_r);
   wire                  dmg_seen = (dmg_r != 8'h00) || rec;
   reg  [`FIC_DW-1:0]    rd_nxt;

   fic_mem #(.W(`FIC_INJW), .AW(`FIC_MAW)) u_inj (
      .clk_in    (clk_in),
      .we_in     (inj_we),
      .waddr_in  (inj_addr_r),
      .wdata_in  (wdata_in[`FIC_INJW-1:0]),
      .raddr_in  ({run_r, slot}),
      .rdata_out (inj_q)
   );

   fic_mem #(.W(`FIC_RESW), .AW(`FIC_MAW)) u_res (
      .clk_in    (clk_in),
      .we_in     (res_we),
      .waddr_in  (res_cnt_r[`FIC_MAW-1:0]),
      .wdata_in  (res_wd),
      .raddr_in  (res_addr_r),
      .rdata_out (res_q)
   );

   fic_cmp u_cmp (
      .faulty_in    (tgt_out_in),
      .golden_in    (gold_out_in),
      .diff_out     (diff),
      .mismatch_out (mismatch)
   );

   // Reset release synchroniser
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rs1_r <= 1'b0;
         rs2_r <= 1'b0;
      end else begin
         rs1_r <= 1'b1;
         rs2_r <= rs1_r;
      end
   end

   always @* begin
      rd_nxt = {`FIC_DW{1'b0}};
      case (addr_in)
         `FIC_A_CTRL:      rd_nxt[`FIC_ST_DONE:`FIC_ST_BUSY] = {done_out, busy_out};
         `FIC_A_OPTS:      rd_nxt[`FIC_OPTW-1:0] = opt_r;
         `FIC_A_DMGLIM:    rd_nxt[`FIC_DMGW-1:0] = dmg_lim_r;
         `FIC_A_MAXINJ:    rd_nxt[`FIC_KW-1:0] = max_inj_r;
         `FIC_A_DUMPINT:   rd_nxt[7:0] = dump_int_r;
         `FIC_A_RELOADINT: rd_nxt[7:0] = rld_int_r;
         `FIC_A_BATCH:     rd_nxt[`FIC_BATW-1:0] = batch_r;
         `FIC_A_VECCNT:    rd_nxt[`FIC_CYCW-1:0] = vec_cnt_r;
         `FIC_A_INJADDR:   rd_nxt[`FIC_MAW-1:0] = inj_addr_r;
         `FIC_A_RESADDR:   rd_nxt[`FIC_MAW-1:0] = res_addr_r;
         `FIC_A_RESDATA:   rd_nxt[`FIC_RESW-1:0] = res_q;
         `FIC_A_RESCNT:    rd_nxt[`FIC_RCW-1:0] = res_cnt_r;
         `FIC_A_POS:       rd_nxt[`FIC_CYCW+`FIC_RUNW-1:0] = {cyc_r, run_r};
         default:          rd_nxt = {`FIC_DW{1'b0}};
      endcase
   end

   // Register port
   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         rdata_out  <= {`FIC_DW{1'b0}};
         opt_r      <= `FIC_OPT_RST;
         dmg_lim_r  <= `FIC_DMG_RST;
         max_inj_r  <= `FIC_MAXINJ_RST;
         dump_int_r <= 8'h00;
         rld_int_r  <= 8'h00;
         batch_r    <= `FIC_BATCH_RST;
         vec_cnt_r  <= 16'h0000;
         inj_addr_r <= 6'h00;
         res_addr_r <= 6'h00;
      end else begin
         rdata_out <= rd_in ? rd_nxt : {`FIC_DW{1'b0}};
         if (inj_we) begin
            inj_addr_r <= inj_addr_r + 6'h01;
         end
         if (wr_in) begin
            case (addr_in)
               `FIC_A_OPTS:      opt_r <= wdata_in[`FIC_OPTW-1:0];
               `FIC_A_DMGLIM:    dmg_lim_r <= wdata_in[`FIC_DMGW-1:0];
               `FIC_A_MAXINJ:    max_inj_r <= (wdata_in[`FIC_DW-1:0] > {29'h0, `FIC_MAXINJ_TOP}) ?
                                              `FIC_MAXINJ_TOP : wdata_in[`FIC_KW-1:0];
               `FIC_A_DUMPINT:   dump_int_r <= wdata_in[7:0];
               `FIC_A_RELOADINT: rld_int_r <= wdata_in[7:0];
               `FIC_A_BATCH:     batch_r <= wdata_in[`FIC_BATW-1:0];
               `FIC_A_VECCNT:    vec_cnt_r <= wdata_in[`FIC_CYCW-1:0];
               `FIC_A_INJADDR:   inj_addr_r <= wdata_in[`FIC_MAW-1:0];
               `FIC_A_RESADDR:   res_addr_r <= wdata_in[`FIC_MAW-1:0];
               default:          ;
            endcase
         end
      end
   end

   // Run sequencer
   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         st_r            <= S_IDLE;
         step_out        <= 1'b0;
         vec_idx_out     <= 16'h0000;
         flip_out        <= 1'b0;
         flip_reg_out    <= 8'h00;
         dump_req_out    <= 1'b0;
         dump_golden_out <= 1'b0;
         reload_req_out  <= 1'b0;
         busy_out        <= 1'b0;
         done_out        <= 1'b0;
         res_cnt_r       <= 7'h00;
         run_r           <= 4'h0;
         cyc_r           <= 16'h0000;
         dmg_r           <= 8'h00;
         injected_r      <= 1'b0;
         k_r             <= 3'h0;
         u_r             <= 3'h0;
         dump_pc_r       <= 8'h00;
         rld_pc_r        <= 8'h00;
         rld_need_r      <= 1'b0;
      end else begin
         step_out <= 1'b0;
         flip_out <= 1'b0;
         if (res_we) begin
            res_cnt_r <= res_cnt_r + 7'h01;
         end
         if (rec) begin
            dmg_r <= dmg_r + 8'h01;
         end
         case (st_r)
            S_IDLE: begin
               if (start) begin
                  busy_out  <= 1'b1;
                  done_out  <= 1'b0;
                  res_cnt_r <= 7'h00;
                  run_r     <= 4'h0;
                  dump_pc_r <= 8'h00;
                  rld_pc_r  <= 8'h00;
                  if (batch_r == 5'h00) begin
                     busy_out <= 1'b0;
                     done_out <= 1'b1;
                  end else if (dump_any) begin
                     dump_req_out    <= 1'b1;
                     dump_golden_out <= 1'b1;
                     st_r            <= S_GDUMP;
                  end else begin
                     st_r <= S_RSTRT;
                  end
               end
            end
            S_GDUMP: begin
               if (dump_done_in) begin
                  dump_req_out    <= 1'b0;
                  dump_golden_out <= 1'b0;
                  st_r            <= S_RSTRT;
               end
            end
            S_RSTRT: begin
               dmg_r      <= 8'h00;
               injected_r <= 1'b0;
               cyc_r      <= 16'h0000;
               k_r         <= 3'h0;
               step_out    <= (vec_cnt_r != 16'h0000);
               vec_idx_out <= 16'h0000;
               st_r        <= (vec_cnt_r == 16'h0000) ? S_ENDR : S_STEP;
            end
            S_STEP: begin
               st_r <= S_CMP; // Target steps here, outputs settle for CMP
            end
            S_CMP: begin
               if (rec && ((dmg_r + 8'h01) == dmg_lim_r) && opt_r[`FIC_OPT_DROP]) begin
                  st_r <= S_ENDR;
               end else begin
                  st_r <= S_ICHK;
               end
            end
            S_ICHK: begin
               if (inj_hit) begin
                  flip_out     <= 1'b1;
                  flip_reg_out <= inj_reg;
                  injected_r   <= 1'b1;
                  k_r          <= k_r + 3'h1;
                  st_r         <= S_INJW;
               end else if (last_cyc) begin
                  st_r <= S_ENDR;
               end else begin
                  cyc_r       <= cyc_r + 16'h0001;
                  step_out    <= 1'b1;
                  vec_idx_out <= cyc_r + 16'h0001;
                  st_r        <= S_STEP;
               end
            end
            S_INJW: begin
               st_r <= S_ICHK;
            end
            S_ENDR: begin
               dump_pc_r  <= period_next(dump_pc_r, dump_int_r);
               rld_pc_r   <= period_next(rld_pc_r, rld_int_r);
               rld_need_r <= (opt_r[`FIC_OPT_RLDERR] && dmg_seen) || period_hit(rld_pc_r, rld_int_r);
               if ((opt_r[`FIC_OPT_DUMPERR] && dmg_seen) || period_hit(dump_pc_r, dump_int_r)) begin
                  dump_req_out <= 1'b1;
                  st_r         <= S_DUMP;
               end else begin
                  st_r <= S_UNFS;
               end
            end
            S_DUMP: begin
               if (dump_done_in) begin
                  dump_req_out <= 1'b0;
                  st_r         <= S_UNFS;
               end
            end
            S_UNFS: begin
               u_r <= 3'h0;
               if (opt_r[`FIC_OPT_UNFLIP] && (k_r != 3'h0)) begin
                  st_r <= S_UNFW;
               end else if (rld_need_r) begin
                  reload_req_out <= 1'b1;
                  st_r           <= S_RLD;
               end else begin
                  st_r <= S_RNEXT;
               end
            end
            S_UNFW: begin
               st_r <= S_UNFF;
            end
            S_UNFF: begin
               flip_out     <= 1'b1;
               flip_reg_out <= inj_reg;
               u_r          <= u_r + 3'h1;
               if ((u_r + 3'h1) != k_r) begin
                  st_r <= S_UNFW;
               end else begin
                  k_r  <= 3'h0; // Last flip issued here, slots undone in injection order, reload decided a cycle later
                  st_r <= S_UNFS;
               end
            end
            S_RLD: begin
               if (reload_done_in) begin
                  reload_req_out <= 1'b0;
                  st_r           <= S_RNEXT;
               end
            end
            S_RNEXT: begin
               if (last_run) begin
                  busy_out <= 1'b0;
                  done_out <= 1'b1;
                  st_r     <= S_IDLE;
               end else begin
                  run_r <= run_r + 4'h1;
                  st_r  <= S_RSTRT;
               end
            end
            default: begin
               st_r <= S_IDLE;
            end
         endcase
      end
   end
endmodule

/* File: fic_runner_checker.sv */
// Port-level assertions for the campaign runner
`include "fic_defines.vh"
module fic_runner_checker (
   input wire                 clk_in,
   input wire                 arst_n_in,
   input wire [`FIC_AW-1:0]   addr_in,
   input wire [`FIC_DW-1:0]   wdata_in,
   input wire                 wr_in,
   input wire                 rd_in,
   input wire [`FIC_DW-1:0]   rdata_out,
   input wire [`FIC_OUTW-1:0] tgt_out_in,
   input wire [`FIC_OUTW-1:0] gold_out_in,
   input wire                 step_out,
   input wire [`FIC_CYCW-1:0] vec_idx_out,
   input wire                 flip_out,
   input wire [`FIC_REGW-1:0] flip_reg_out,
   input wire                 dump_req_out,
   input wire                 dump_golden_out,
   input wire                 dump_done_in,
   input wire                 reload_req_out,
   input wire                 reload_done_in,
   input wire                 busy_out,
   input wire                 done_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   wire start_w = wr_in && addr_in == `FIC_A_CTRL && wdata_in[`FIC_CTRL_START];
   step_pulse_a: assert property (step_out |=> !step_out [*2]) else $error("step spacing");
   compare_first_a: assert property (step_out |=> !flip_out) else $error("flip before compare");
   flip_pulse_a: assert property (flip_out |-> !step_out ##1 !flip_out) else $error("flip shape");
   dump_hold_a: assert property (dump_req_out && !dump_done_in |=> dump_req_out) else $error("dump drop");
   reload_hold_a: assert property (reload_req_out && !reload_done_in |=> reload_req_out) else $error("reload drop");
   golden_tag_a: assert property (dump_golden_out |-> dump_req_out) else $error("golden w/o dump");
   end_quiet_a: assert property (dump_req_out || reload_req_out |-> !step_out && !flip_out
      && !(dump_req_out && reload_req_out)) else $error("end actions overlap");
   run_in_batch_a: assert property (step_out || flip_out |-> busy_out && !done_out) else $error("idle step");
   start_taken_a: assert property (start_w && !busy_out |=> busy_out && !done_out) else $error("no start");
   done_hold_a: assert property (done_out && !start_w |=> done_out) else $error("results lost");
   read_idle_a: assert property (!$past(rd_in) |-> rdata_out == '0) else $error("stray read data");
   cover property (dump_req_out && dump_golden_out);
   cover property (reload_req_out && reload_done_in);
   cover property (flip_out ##2 flip_out);
   cover property (start_w && !busy_out);
endmodule

/* File: fic_target_model.sv */
// Behavioural emulation target pair facing the campaign runner
module fic_target_model (
   input  logic        clk_in,
   input  logic [3:0]  dly_in,
   input  logic        step_in,
   input  logic [15:0] vec_idx_in,
   input  logic        flip_in,
   input  logic [7:0]  flip_reg_in,
   input  logic        dump_req_in,
   input  logic        dump_golden_in,
   input  logic        reload_req_in,
   output logic [7:0]  faulty_out,
   output logic [7:0]  golden_out,
   output logic        dump_done_out = 1'b0,
   output logic        reload_done_out = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0]  state_r = 8'h00;
   logic [7:0]  cur_r = 8'h00;
   logic [15:0] last_r = 16'h0000;
   logic [3:0]  wait_r = 4'h0;
   logic        rl_seen_r = 1'b0;
   int          n_step = 0, n_flip = 0, n_dump = 0, n_gdump = 0, n_reload = 0, n_viol = 0;
   // Faulty copy differs from the clean one only in flipped bits
   assign faulty_out = cur_r ^ state_r;
   assign golden_out = cur_r;
   always @(posedge clk_in) begin
      dump_done_out   <= 1'b0;
      reload_done_out <= 1'b0;
      if (step_in) begin
         if (vec_idx_in != 16'h0000 && vec_idx_in != last_r + 16'h0001) n_viol++;
         cur_r     <= vec_idx_in[7:0];
         last_r    <= vec_idx_in;
         rl_seen_r <= 1'b0;
         n_step++;
      end
      if (flip_in) begin
         state_r[flip_reg_in[2:0]] <= ~state_r[flip_reg_in[2:0]];
         if (rl_seen_r) n_viol++;
         n_flip++;
      end
      if ((dump_req_in || reload_req_in) && !dump_done_out && !reload_done_out) begin
         if (wait_r == dly_in) begin
            wait_r <= 4'h0;
            if (dump_req_in) begin
               dump_done_out <= 1'b1;
               n_dump++;
               if (dump_golden_in) n_gdump++;
               if (rl_seen_r) n_viol++;
            end else begin
               reload_done_out <= 1'b1;
               state_r         <= 8'h00;
               rl_seen_r       <= 1'b1;
               n_reload++;
            end
         end else begin
            wait_r <= wait_r + 4'h1;
         end
      end
   end
endmodule

/* File: testbench.sv */
// Self-checking bench for the campaign runner
`include "fic_defines.vh"
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic                 clk_in = 1'b0, arst_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
   logic [`FIC_AW-1:0]   addr_in = '0;
   logic [`FIC_DW-1:0]   wdata_in = '0, rdata_out, rv;
   logic [`FIC_OUTW-1:0] tgt_out_in, gold_out_in;
   logic [`FIC_CYCW-1:0] vec_idx_out;
   logic [`FIC_REGW-1:0] flip_reg_out;
   logic                 step_out, flip_out, dump_req_out, dump_golden_out, dump_done_in;
   logic                 reload_req_out, reload_done_in, busy_out, done_out;
   logic [3:0]           dly = 4'h0;
   int                   n_mismatch = 0, checked = 0, n;
   logic [3:0]           ra [8] = '{4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'h4, 4'hc, 4'he};
   logic [31:0]          rx [8] = '{32'h2, 32'h1, 32'h1, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0};
   fic_runner dut_u (.clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .tgt_out_in(tgt_out_in),
      .gold_out_in(gold_out_in), .step_out(step_out), .vec_idx_out(vec_idx_out), .flip_out(flip_out),
      .flip_reg_out(flip_reg_out), .dump_req_out(dump_req_out), .dump_golden_out(dump_golden_out),
      .dump_done_in(dump_done_in), .reload_req_out(reload_req_out), .reload_done_in(reload_done_in),
      .busy_out(busy_out), .done_out(done_out));
   fic_target_model model_u (.clk_in(clk_in), .dly_in(dly), .step_in(step_out), .vec_idx_in(vec_idx_out),
      .flip_in(flip_out), .flip_reg_in(flip_reg_out), .dump_req_in(dump_req_out),
      .dump_golden_in(dump_golden_out), .reload_req_in(reload_req_out), .faulty_out(tgt_out_in),
      .golden_out(gold_out_in), .dump_done_out(dump_done_in), .reload_done_out(reload_done_in));
   initial begin
      forever #50 clk_in = ~clk_in;
   end
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr_in  <= a;
      wdata_in <= d;
      wr_in    <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      @(negedge clk_in);
      rv = rdata_out;
   endtask
   task automatic inj(input logic [5:0] s, input logic [15:0] c, input logic [7:0] r, input logic v);
      wr(`FIC_A_INJADDR, {26'h0, s});
      wr(`FIC_A_INJDATA, {7'h0, v, c, r});
   endtask
   task automatic res(input logic [5:0] i, input logic [3:0] r, input logic [15:0] c, input logic [7:0] m);
      wr(`FIC_A_RESADDR, {26'h0, i});
      @(posedge clk_in);
      rd(`FIC_A_RESDATA);
      `CHK(rv, {4'h0, r, c, m})
   endtask
   task automatic go(input logic [4:0] b, input logic [31:0] cnt);
      wr(`FIC_A_BATCH, {27'h0, b});
      wr(`FIC_A_CTRL, 32'h1);
      repeat (2) @(posedge clk_in);
      for (n = 0; n < 3000 && done_out !== 1'b1; n++) @(posedge clk_in);
      `CHK(done_out, 1'b1)
      rd(`FIC_A_RESCNT);
      `CHK(rv, cnt)
   endtask
   task automatic test_done();
      $display("mismatches %0d comparisons %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #3000000;
      n_mismatch++;
      test_done();
   end
   initial begin
      repeat (12) @(posedge clk_in);
      arst_n_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      foreach (ra[i]) begin
         rd(ra[i]);
         `CHK(rv, rx[i])
      end
      wr(`FIC_A_MAXINJ, 32'h7);
      rd(`FIC_A_MAXINJ);
      `CHK(rv, 32'h4)
      wr(`FIC_A_MAXINJ, 32'h1);
      wr(`FIC_A_INJADDR, 32'h0);
      repeat (64) wr(`FIC_A_INJDATA, 32'h0);
      // Default options: late compare, drop on first damage
      wr(`FIC_A_VECCNT, 32'h4);
      inj(6'd0, 16'd1, 8'd3, 1'b1);
      go(5'd2, 32'h1);
      res(6'd0, 4'd0, 16'd2, 8'h00);
      `CHK(model_u.n_step, 7)
      `CHK(model_u.n_flip, 1)
      `CHK(model_u.state_r, 8'h08)
      // Residual check, mask, no drop, limit two, unflip
      wr(`FIC_A_OPTS, 32'h0d);
      wr(`FIC_A_DMGLIM, 32'h2);
      inj(6'd0, 16'd2, 8'd0, 1'b1);
      go(5'd1, 32'h2);
      res(6'd0, 4'd0, 16'd0, 8'h08);
      res(6'd1, 4'd0, 16'd1, 8'h08);
      `CHK(model_u.n_step, 11)
      `CHK(model_u.n_flip, 3)
      `CHK(model_u.state_r, 8'h08)
      // Dump and reload after damage, periodic dump, slow target
      dly <= 4'h6;
      wr(`FIC_A_OPTS, 32'h30);
      wr(`FIC_A_DMGLIM, 32'h1);
      wr(`FIC_A_DUMPINT, 32'h2);
      inj(6'd0, 16'd0, 8'd1, 1'b1);
      inj(6'd1, 16'd1, 8'd2, 1'b1);
      go(5'd3, 32'h1);
      res(6'd0, 4'd0, 16'd1, 8'h00);
      `CHK(model_u.n_step, 23)
      `CHK(model_u.n_flip, 4)
      `CHK(model_u.n_gdump, 1)
      `CHK(model_u.n_dump, 3)
      `CHK(model_u.n_reload, 1)
      `CHK(model_u.state_r, 8'h00)
      // Periodic reload only, prompt target
      dly <= 4'h0;
      wr(`FIC_A_OPTS, 32'h02);
      wr(`FIC_A_DUMPINT, 32'h0);
      wr(`FIC_A_RELOADINT, 32'h2);
      inj(6'd0, 16'd0, 8'd0, 1'b0);
      inj(6'd1, 16'd0, 8'd0, 1'b0);
      go(5'd2, 32'h0);
      `CHK(model_u.n_reload, 2)
      `CHK(model_u.n_dump, 3)
      `CHK(model_u.n_step, 31)
      `CHK(model_u.n_viol, 0)
      rd(`FIC_A_CTRL);
      `CHK(rv, 32'h2)
      test_done();
   end
endmodule
bind fic_runner fic_runner_checker chk_u (.clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in),
   .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .tgt_out_in(tgt_out_in),
   .gold_out_in(gold_out_in), .step_out(step_out), .vec_idx_out(vec_idx_out), .flip_out(flip_out),
   .flip_reg_out(flip_reg_out), .dump_req_out(dump_req_out), .dump_golden_out(dump_golden_out),
   .dump_done_in(dump_done_in), .reload_req_out(reload_req_out), .reload_done_in(reload_done_in),
   .busy_out(busy_out), .done_out(done_out));
